// File: hdl/csg_consts.svh
// constants for the conversion signal generators: offsets, fields, resets
// assumes inclusion by the package and the single design module
`ifndef CSG_CONSTS_SVH
`define CSG_CONSTS_SVH
`define CSG_ADDR_W 12
`define CSG_OFF_CLK1 12'h320
`define CSG_OFF_CLK2 12'h324
`define CSG_OFF_FRATE 12'h32c
`define CSG_OFF_FCOUNT 12'h330
`define CSG_OFF_ENABLE 12'h33c
`define CSG_DIV_MSB 27
`define CSG_REF_MSB 30
`define CSG_REF_LSB 29
`define CSG_FSEL_BIT 29
`define CSG_EN_CLK1_BIT 0
`define CSG_EN_CLK2_BIT 1
`define CSG_EN_FRAME_BIT 8
`define CSG_DIV_RESET 28'hfffffff
`define CSG_COUNT_RESET 28'h0000000
`define CSG_REF_RESET 2'h0
`define CSG_REF_20 2'h0
`define CSG_REF_2205 2'h1
`define CSG_REF_60 2'h2
`endif

// File: hdl/csg_pkg.sv
// types shared by the conversion signal generators
// assumes csg_consts.svh is on the include path
`include "csg_consts.svh"
package csg_pkg;
    typedef logic [`CSG_DIV_MSB:0] csg_div_t;
    typedef logic [1:0] csg_ref_t;
endpackage

// File: hdl/csg_top.sv
// conversion clock and frame trigger generators with their register file
// assumes three reference clock ticks arrive as async levels from outside
`timescale 1ns/1ps
`include "csg_consts.svh"
module csg_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [`CSG_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic [2:0] REF_TICK,
    output logic CONV_CLOCK_ONE,
    output logic CONV_CLOCK_TWO,
    output logic FRAME_PULSE,
    output logic FRAME_BUSY
);

////////////////////////////////////////////////////////////////////////
// registers
csg_pkg::csg_div_t clock_one_divider, clock_two_divider, frame_pulse_divider, frame_pulse_count;
csg_pkg::csg_ref_t clock_one_reference_select, clock_two_reference_select;
logic frame_pulse_input_select, clock_one_run, clock_two_run, frame_pulse_run;

// register writes; the port address is the documented offset
always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        clock_one_divider <= `CSG_DIV_RESET;
        clock_two_divider <= `CSG_DIV_RESET;
        frame_pulse_divider <= `CSG_DIV_RESET;
        frame_pulse_count <= `CSG_COUNT_RESET;
        clock_one_reference_select <= `CSG_REF_RESET;
        clock_two_reference_select <= `CSG_REF_RESET;
        frame_pulse_input_select <= 1'b0;
        clock_one_run <= 1'b0;
        clock_two_run <= 1'b0;
        frame_pulse_run <= 1'b0;
    end else if (REG_WR) begin
        unique case (REG_ADDR)
            `CSG_OFF_CLK1: begin
                clock_one_divider <= REG_WDATA[`CSG_DIV_MSB:0];
                clock_one_reference_select <= REG_WDATA[`CSG_REF_MSB:`CSG_REF_LSB];
            end
            `CSG_OFF_CLK2: begin
                clock_two_divider <= REG_WDATA[`CSG_DIV_MSB:0];
                clock_two_reference_select <= REG_WDATA[`CSG_REF_MSB:`CSG_REF_LSB];
            end
            `CSG_OFF_FRATE: begin
                frame_pulse_divider <= REG_WDATA[`CSG_DIV_MSB:0];
                frame_pulse_input_select <= REG_WDATA[`CSG_FSEL_BIT];
            end
            `CSG_OFF_FCOUNT: frame_pulse_count <= REG_WDATA[`CSG_DIV_MSB:0];
            `CSG_OFF_ENABLE: begin
                clock_one_run <= REG_WDATA[`CSG_EN_CLK1_BIT];
                clock_two_run <= REG_WDATA[`CSG_EN_CLK2_BIT];
                frame_pulse_run <= REG_WDATA[`CSG_EN_FRAME_BIT];
            end
            default: ;
        endcase
    end
end

// read data from flops; unmapped and reserved bits read zero
always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
        unique case (REG_ADDR)
            `CSG_OFF_CLK1: REG_RDATA <= {1'b0, clock_one_reference_select, 1'b0, clock_one_divider};
            `CSG_OFF_CLK2: REG_RDATA <= {1'b0, clock_two_reference_select, 1'b0, clock_two_divider};
            `CSG_OFF_FRATE: REG_RDATA <= {2'h0, frame_pulse_input_select, 1'b0, frame_pulse_divider};
            `CSG_OFF_FCOUNT: REG_RDATA <= {4'h0, frame_pulse_count};
            `CSG_OFF_ENABLE: REG_RDATA <= {23'h0, frame_pulse_run, 6'h0, clock_two_run, clock_one_run};
            default: REG_RDATA <= 32'h0;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// reference tick synchronisers and rising-edge detect
logic [2:0] ref_meta, ref_sync, ref_last, ref_tick;
always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        ref_meta <= 3'h0;
        ref_sync <= 3'h0;
        ref_last <= 3'h0;
    end else begin
        ref_meta <= REF_TICK;
        ref_sync <= ref_meta;
        ref_last <= ref_sync;
    end
end
assign ref_tick = ref_sync & ~ref_last;

////////////////////////////////////////////////////////////////////////
// two clock generators; code 3 is reserved and never ticks
logic [1:0] gen_run, gen_out, gen_period;
csg_pkg::csg_div_t gen_div [2];
csg_pkg::csg_ref_t gen_ref [2];
assign gen_run = {clock_two_run, clock_one_run};
assign gen_div[0] = clock_one_divider;
assign gen_div[1] = clock_two_divider;
assign gen_ref[0] = clock_one_reference_select;
assign gen_ref[1] = clock_two_reference_select;

genvar g;
generate
    for (g = 0; g < 2; g++) begin : gen_clk
        csg_pkg::csg_div_t half_cnt;
        logic src_tick;
        // 22.05 MHz is not an integer multiple of the system clock, hence external ticks
        assign src_tick = (gen_ref[g] == `CSG_REF_20) ? ref_tick[0] :
                          (gen_ref[g] == `CSG_REF_2205) ? ref_tick[1] :
                          (gen_ref[g] == `CSG_REF_60) ? ref_tick[2] : 1'b0;
        // one output period per divider plus one source ticks; the low phase is one tick shorter for an even divider, equal for an odd one
        always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
                half_cnt <= `CSG_COUNT_RESET;
                gen_out[g] <= 1'b1;
            end else if (!gen_run[g]) begin
                half_cnt <= `CSG_COUNT_RESET;
                gen_out[g] <= 1'b1;
            end else if (src_tick) begin
                if (half_cnt >= gen_div[g]) begin
                    half_cnt <= `CSG_COUNT_RESET;
                    gen_out[g] <= 1'b1;
                end else begin
                    half_cnt <= half_cnt + 28'h1;
                    if (half_cnt == (gen_div[g] >> 1)) gen_out[g] <= 1'b0;
                end
            end
        end
        // one pulse on each completed output period
        assign gen_period[g] = gen_run[g] && src_tick && (half_cnt >= gen_div[g]);
    end
endgenerate
assign CONV_CLOCK_ONE = gen_out[0];
assign CONV_CLOCK_TWO = gen_out[1];

////////////////////////////////////////////////////////////////////////
// frame trigger generator
logic frame_in;
csg_pkg::csg_div_t frame_cnt, frame_done;
assign frame_in = frame_pulse_input_select ? gen_period[1] : gen_period[0];
// outputs only serve sequencer-mode converters; mode gating lives in those sequencers
always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        frame_cnt <= `CSG_COUNT_RESET;
        frame_done <= `CSG_COUNT_RESET;
        FRAME_PULSE <= 1'b0;
    end else if (!frame_pulse_run) begin
        frame_cnt <= `CSG_COUNT_RESET;
        frame_done <= `CSG_COUNT_RESET;
        FRAME_PULSE <= 1'b0;
    end else begin
        FRAME_PULSE <= 1'b0;
        if (frame_in && (frame_pulse_count == `CSG_COUNT_RESET || frame_done < frame_pulse_count)) begin
            if (frame_cnt >= frame_pulse_divider) begin
                frame_cnt <= `CSG_COUNT_RESET;
                FRAME_PULSE <= 1'b1;
                if (frame_pulse_count != `CSG_COUNT_RESET) frame_done <= frame_done + 28'h1;
            end else begin
                frame_cnt <= frame_cnt + 28'h1;
            end
        end
    end
end
assign FRAME_BUSY = frame_pulse_run && (frame_pulse_count == `CSG_COUNT_RESET || frame_done < frame_pulse_count);

////////////////////////////////////////////////////////////////////////
// checks
property p_clk_idle;
    @(posedge CLK_SYS) disable iff (RST) !clock_one_run |=> CONV_CLOCK_ONE;
endproperty
a_clk_idle: assert property (p_clk_idle) else $error("disabled clock one not high");
property p_clk2_idle;
    @(posedge CLK_SYS) disable iff (RST) $fell(clock_two_run) |=> CONV_CLOCK_TWO && gen_clk[1].half_cnt == 28'h0;
endproperty
a_clk2_idle: assert property (p_clk2_idle) else $error("clock two not held high");
property p_no_pulse_off;
    @(posedge CLK_SYS) disable iff (RST) !frame_pulse_run |=> !FRAME_PULSE;
endproperty
a_no_pulse_off: assert property (p_no_pulse_off) else $error("frame pulse while disabled");
property p_count_limit;
    @(posedge CLK_SYS) disable iff (RST)
        frame_pulse_count != `CSG_COUNT_RESET && frame_done >= frame_pulse_count |=> !FRAME_PULSE;
endproperty
a_count_limit: assert property (p_count_limit) else $error("frame count exceeded");
property p_pulse_cause;
    @(posedge CLK_SYS) disable iff (RST) FRAME_PULSE |-> $past(frame_in) && $past(frame_pulse_run);
endproperty
a_pulse_cause: assert property (p_pulse_cause) else $error("frame pulse without input period");
property p_period_reset;
    @(posedge CLK_SYS) disable iff (RST) gen_period[0] |=> clock_one_run -> (gen_clk[0].half_cnt == 28'h0);
endproperty
a_period_reset: assert property (p_period_reset) else $error("divider did not wrap");
property p_reserved_src;
    @(posedge CLK_SYS) disable iff (RST) clock_one_reference_select == 2'h3 |-> !gen_period[0];
endproperty
a_reserved_src: assert property (p_reserved_src) else $error("reserved source ticked");
property p_endless;
    @(posedge CLK_SYS) disable iff (RST)
        frame_pulse_run && frame_pulse_count == `CSG_COUNT_RESET && frame_in && frame_cnt >= frame_pulse_divider
        |=> FRAME_PULSE;
endproperty
a_endless: assert property (p_endless) else $error("endless mode stopped");
endmodule

// File: tb/conversion_signal_generators_test.sv
// self-checking bench for the conversion signal generators
// assumes ref half periods 4,5,6 cycles, so tick periods 8,10,12
`timescale 1ns/1ps
module conversion_signal_generators_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [2:0] ref_tick;
    logic conv_one, conv_two, frame_pulse, frame_busy, hi;
    int pulse_count, base, err_count = 0, n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    csg_top csg_top_i (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REF_TICK(ref_tick), .CONV_CLOCK_ONE(conv_one),
        .CONV_CLOCK_TWO(conv_two), .FRAME_PULSE(frame_pulse), .FRAME_BUSY(frame_busy));
    csg_ref_model csg_ref_model_i (.clk_sys(clk_sys), .frame_pulse(frame_pulse), .ref_tick(ref_tick),
        .pulse_count(pulse_count));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("counts: compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(nm, exp, reg_rdata);
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? conv_one : (w == 1) ? conv_two : frame_pulse;
    endfunction
    // first whole period skipped: a reprogram may stretch it
    task automatic per(input int w, input int exp, input string nm);
        int n, rises, t2;
        logic prev, cur;
        n = 0;
        rises = 0;
        t2 = 0;
        prev = pick(w);
        while (rises < 3 && n < 4000) begin
            @(negedge clk_sys);
            n++;
            cur = pick(w);
            if (cur === 1'b1 && prev !== 1'b1) begin
                rises++;
                t2 = (rises == 2) ? n : t2;
            end
            prev = cur;
        end
        if (rises < 3) begin
            err_count++;
            $display("[FAIL] %s expected 3 rises seen %0d", nm, rises);
            end_sim();
        end
        chk(nm, 32'(exp), 32'(n - t2));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        rd(12'h320, 32'h0fffffff, "clock one config");
        rd(12'h324, 32'h0fffffff, "clock two config");
        rd(12'h32c, 32'h0fffffff, "frame rate config");
        rd(12'h330, 32'h00000000, "frame count config");
        rd(12'h33c, 32'h00000000, "enable");
        chk("idle clocks", 32'h3, {30'h0, conv_one, conv_two});
        wr(12'h32c, 32'hffffffff);
        rd(12'h32c, 32'h2fffffff, "frame rate fields");
        wr(12'h334, 32'hffffffff);
        rd(12'h334, 32'h00000000, "unmapped");
        wr(12'h33c, 32'hffffffff);
        rd(12'h33c, 32'h00000103, "enable fields");
        wr(12'h33c, 32'h0);
        wr(12'h320, 32'h00000001);
        wr(12'h324, 32'h40000002);
        repeat (60) @(negedge clk_sys);
        chk("clocks before enable", 32'h3, {30'h0, conv_one, conv_two});
        $display("test registers done");
        wr(12'h33c, 32'h3);
        for (int s = 0; s < 3; s++) begin
            wr(12'h320, {1'b0, 2'(s), 29'h1});
            per(0, 4 * (4 + s), "clock one period");
        end
        per(1, 36, "clock two period");
        // reserved source code must freeze clock one where it stands
        wr(12'h320, 32'h60000001);
        rd(12'h320, 32'h60000001, "reserved source config");
        hi = conv_one;
        base = 0;
        repeat (50) begin
            @(negedge clk_sys);
            base += (conv_one !== hi) ? 1 : 0;
        end
        chk("reserved source frozen", 32'h0, 32'(base));
        wr(12'h33c, 32'h2);
        hi = 1'b1;
        repeat (40) begin
            @(negedge clk_sys);
            hi &= conv_one;
        end
        chk("disabled clock high", 32'h1, {31'h0, hi});
        $display("test clocks done");
        wr(12'h32c, 32'h20000001);
        wr(12'h330, 32'h3);
        base = pulse_count;
        repeat (200) @(negedge clk_sys);
        chk("pulses before enable", 32'(base), 32'(pulse_count));
        wr(12'h33c, 32'h102);
        repeat (600) @(negedge clk_sys);
        chk("counted pulses", 32'h3, 32'(pulse_count - base));
        chk("busy after count", 32'h0, {31'h0, frame_busy});
        wr(12'h33c, 32'h2);
        wr(12'h330, 32'h0);
        wr(12'h33c, 32'h102);
        per(2, 72, "frame spacing");
        chk("busy endless", 32'h1, {31'h0, frame_busy});
        wr(12'h33c, 32'h2);
        repeat (5) @(negedge clk_sys);
        base = pulse_count;
        repeat (200) @(negedge clk_sys);
        chk("pulses after disable", 32'(base), 32'(pulse_count));
        $display("test frames done");
        end_sim();
    end
endmodule

// File: tb/csg_ref_model.sv
// reference oscillators and frame consumer beside the generators
// assumes the bench clock; ticks derive from it so rates repeat exactly
`timescale 1ns/1ps
module csg_ref_model #(
    parameter int HALF0 = 4,
    parameter int HALF1 = 5,
    parameter int HALF2 = 6
) (
    input wire logic clk_sys,
    input wire logic frame_pulse,
    output logic [2:0] ref_tick,
    output int pulse_count
);
    int half [3] = '{HALF0, HALF1, HALF2};
    int cnt [3] = '{0, 0, 0};
    initial begin
        ref_tick = 3'h0;
        pulse_count = 0;
    end
    // square waves, slow against the system clock so the sync never drops an edge
    always @(negedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] = cnt[i] + 1;
            if (cnt[i] == half[i]) begin
                cnt[i] = 0;
                ref_tick[i] = ~ref_tick[i];
            end
        end
    end
    // a sequencer sees one trigger per high cycle
    always @(posedge clk_sys) begin
        if (frame_pulse === 1'b1) begin
            pulse_count++;
        end
    end
endmodule
